// *** src/skip_move_exec.sv ***
// Function
// - Decrement-skip: register minus one to selected target; no flags.
// - Zero result replaces next instruction with idle cycle; two cycles.
// - Increment-skip: plus one to target; skip on zero; no flags.
// - OR immediate into accumulator; only nil flag updated.
// - Load immediate into accumulator; flags untouched.
// - OR accumulator with register into selected target; nil flag updated.
// - Store accumulator into addressed register; flags untouched.
`timescale 1ns/100ps
`default_nettype none

module skip_move_exec
   import skip_move_pkg::*;
#(
   parameter int DATA_WIDTH = DATA_W
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [INSTR_W-1:0] instr_word,
   input wire logic [DATA_WIDTH-1:0] file_rd_data,
   output logic [ADDR_W-1:0] file_addr,
   output logic [DATA_WIDTH-1:0] file_wr_data,
   output logic file_wr_en,
   output logic [DATA_WIDTH-1:0] accumulator,
   output logic nil_flag_wr_en,
   output logic nil_flag_value,
   output logic skip_active,
   output logic handled
);

   // ------------------------------------------------------------
   // Decode
   // ------------------------------------------------------------
   op_e op;
   logic dest_reg;
   logic [DATA_WIDTH-1:0] imm;
   logic [ADDR_W-1:0] addr;

   always_comb begin
      op = OP_NONE;
      if (instr_word[OPC_HI:OPC_LO] == OPC_DEC_SKIP) begin
         op = OP_DEC_SKIP;
      end else if (instr_word[OPC_HI:OPC_LO] == OPC_INC_SKIP) begin
         op = OP_INC_SKIP;
      end else if (instr_word[OPC_HI:OPC_LO] == OPC_OR_REG) begin
         op = OP_OR_REG;
      end else if (instr_word[OPC_HI:OPC_LO] == OPC_OR_IMM) begin
         op = OP_OR_IMM;
      end else if (instr_word[OPC_HI:LIT_OPC_LO] == OPC_LOAD_IMM) begin
         // Don't-care bits 9:8 assumed zero by the generator
         op = OP_LOAD_IMM;
      end else if (instr_word[OPC_HI:DEST_BIT] == OPC_STORE_HI) begin
         op = OP_STORE;
      end
   end

   assign dest_reg = instr_word[DEST_BIT];
   assign imm = instr_word[DATA_WIDTH-1:0];
   assign addr = instr_word[ADDR_W-1:0];

   // ------------------------------------------------------------
   // Execute
   // ------------------------------------------------------------
   logic take;
   logic skip_op;
   logic writes_reg;
   logic writes_acc;
   logic [DATA_WIDTH-1:0] result;
   logic result_nil;
   logic [DATA_WIDTH-1:0] acc_r, acc_nxt;
   logic [DATA_WIDTH-1:0] wdata_r, wdata_nxt;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic wen_r, wen_nxt;
   logic zwe_r, zwe_nxt;
   logic zval_r, zval_nxt;
   logic skip_r, skip_nxt;
   logic hand_r, hand_nxt;

   // Slot under a pending skip is dropped and acts as an idle cycle
   assign take = instr_valid && !skip_r;
   assign skip_op = (op == OP_DEC_SKIP) || (op == OP_INC_SKIP);

   always_comb begin
      result = '0;
      case (op)
         OP_DEC_SKIP: begin
            result = file_rd_data - 1'b1;
         end
         OP_INC_SKIP: begin
            result = file_rd_data + 1'b1;
         end
         OP_OR_REG: begin
            result = acc_r | file_rd_data;
         end
         OP_OR_IMM: begin
            result = acc_r | imm;
         end
         OP_LOAD_IMM: begin
            result = imm;
         end
         OP_STORE: begin
            result = acc_r;
         end
         default: begin
            result = '0;
         end
      endcase
   end

   // Zero test on the full 8-bit result, so wrap-around counts as zero
   assign result_nil = (result == '0);

   always_comb begin
      writes_reg = 1'b0;
      writes_acc = 1'b0;
      case (op)
         OP_DEC_SKIP, OP_INC_SKIP, OP_OR_REG: begin
            writes_reg = dest_reg;
            writes_acc = !dest_reg;
         end
         OP_OR_IMM, OP_LOAD_IMM: begin
            writes_acc = 1'b1;
         end
         OP_STORE: begin
            writes_reg = 1'b1;
         end
         default: begin
            writes_reg = 1'b0;
            writes_acc = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Accumulator
   // ------------------------------------------------------------
   always_comb begin
      acc_nxt = acc_r;
      if (take && writes_acc) begin
         acc_nxt = result;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         acc_r <= ACC_RESET;
      end else begin
         acc_r <= acc_nxt;
      end
   end

   // ------------------------------------------------------------
   // Register file write port
   // ------------------------------------------------------------
   // Data holds after a write; address loads on every taken slot; only the enable pulses
   always_comb begin
      addr_nxt = addr_r;
      wdata_nxt = wdata_r;
      wen_nxt = 1'b0;
      if (take) begin
         addr_nxt = addr;
      end
      if (take && writes_reg) begin
         wdata_nxt = result;
         wen_nxt = 1'b1;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         addr_r <= ADDR_RESET[ADDR_W-1:0];
         wdata_r <= ACC_RESET;
         wen_r <= 1'b0;
      end else begin
         addr_r <= addr_nxt;
         wdata_r <= wdata_nxt;
         wen_r <= wen_nxt;
      end
   end

   // ------------------------------------------------------------
   // Nil flag request
   // ------------------------------------------------------------
   // Only the two OR forms touch the flag; skips and moves leave it
   always_comb begin
      zwe_nxt = 1'b0;
      zval_nxt = zval_r;
      if (take && (op == OP_OR_REG || op == OP_OR_IMM)) begin
         zwe_nxt = 1'b1;
         zval_nxt = result_nil;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         zwe_r <= 1'b0;
         zval_r <= 1'b0;
      end else begin
         zwe_r <= zwe_nxt;
         zval_r <= zval_nxt;
      end
   end

   // ------------------------------------------------------------
   // Skip and slot status
   // ------------------------------------------------------------
   // Pending skip waits for the next valid slot, however late it comes
   always_comb begin
      skip_nxt = skip_r;
      hand_nxt = 1'b0;
      if (instr_valid) begin
         skip_nxt = 1'b0;
      end
      if (take) begin
         hand_nxt = (op != OP_NONE);
         skip_nxt = skip_op && result_nil;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         skip_r <= 1'b0;
         hand_r <= 1'b0;
      end else begin
         skip_r <= skip_nxt;
         hand_r <= hand_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign file_addr = addr_r;
   assign file_wr_data = wdata_r;
   assign file_wr_en = wen_r;
   assign accumulator = acc_r;
   assign nil_flag_wr_en = zwe_r;
   assign nil_flag_value = zval_r;
   assign skip_active = skip_r;
   assign handled = hand_r;

endmodule

`default_nettype wire

// *** src/skip_move_pkg.sv ***
package skip_move_pkg;

   // --------------------------------------------------------------
   // Instruction word layout (14-bit core word)
   // --------------------------------------------------------------
   localparam int INSTR_W = 14;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 7;
   localparam int DEST_BIT = 7;
   localparam int OPC_HI = 13;
   localparam int OPC_LO = 8;
   localparam int LIT_OPC_LO = 10;

   // --------------------------------------------------------------
   // Opcodes
   // --------------------------------------------------------------
   localparam logic [5:0] OPC_DEC_SKIP = 6'h0B;
   localparam logic [5:0] OPC_INC_SKIP = 6'h0F;
   localparam logic [5:0] OPC_OR_REG = 6'h04;
   localparam logic [5:0] OPC_OR_IMM = 6'h38;
   localparam logic [3:0] OPC_LOAD_IMM = 4'hC;
   localparam logic [6:0] OPC_STORE_HI = 7'h01;

   // --------------------------------------------------------------
   // Reset values
   // --------------------------------------------------------------
   localparam logic [7:0] ACC_RESET = 8'h00;
   localparam logic [7:0] ADDR_RESET = 8'h00;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_DEC_SKIP,
      OP_INC_SKIP,
      OP_OR_IMM,
      OP_LOAD_IMM,
      OP_OR_REG,
      OP_STORE
   } op_e;

endpackage

// *** tb/skip_move_props.sv ***
`timescale 1ns/100ps
`default_nettype none
module skip_move_props
   import skip_move_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic instr_valid,
   input wire logic [13:0] instr_word,
   input wire logic [7:0] file_rd_data,
   input wire logic [6:0] file_addr,
   input wire logic [7:0] file_wr_data,
   input wire logic file_wr_en,
   input wire logic [7:0] accumulator,
   input wire logic nil_flag_wr_en,
   input wire logic nil_flag_value,
   input wire logic skip_active,
   input wire logic handled
);
   // ------------------------------
   // Properties
   // ------------------------------
   wire tk = instr_valid && !skip_active;
   wire [5:0] op = instr_word[13:8];
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   a_dec_no_flag: assert property (
      tk && op == OPC_DEC_SKIP |=> handled && !nil_flag_wr_en)
      else $error("dec flag");
   a_dec_skip: assert property (
      tk && op == OPC_DEC_SKIP && file_rd_data == 8'h01 |=> skip_active)
      else $error("no skip");
   a_inc_skip: assert property (
      tk && op == OPC_INC_SKIP && file_rd_data == 8'hFF
      |=> skip_active && !nil_flag_wr_en)
      else $error("inc skip");
   a_or_imm: assert property (
      tk && op == OPC_OR_IMM
      |=> accumulator == ($past(accumulator) | 8'($past(instr_word))))
      else $error("or imm");
   a_load_imm: assert property (
      tk && instr_word[13:10] == OPC_LOAD_IMM
      |=> accumulator == 8'($past(instr_word)) && !nil_flag_wr_en)
      else $error("load imm");
   a_or_reg_flag: assert property (
      tk && op == OPC_OR_REG |=> nil_flag_wr_en) else $error("or reg flag");
   a_store_reg: assert property (
      tk && instr_word[13:7] == OPC_STORE_HI
      |=> file_wr_en && file_wr_data == $past(accumulator) && !nil_flag_wr_en)
      else $error("store");
   a_nil_value: assert property (
      nil_flag_wr_en |-> nil_flag_value
         == ((file_wr_en ? file_wr_data : accumulator) == 8'h00))
      else $error("nil");
   a_skip_drop: assert property (
      skip_active && instr_valid |=> !handled && !file_wr_en)
      else $error("slot not dropped");
   a_skip_hold: assert property (
      skip_active && instr_valid
      |=> accumulator == $past(accumulator) && !skip_active)
      else $error("skipped slot changed state");
endmodule
bind skip_move_exec skip_move_props i_props (
   .core_clk(core_clk),
   .rst(rst),
   .instr_valid(instr_valid),
   .instr_word(instr_word),
   .file_rd_data(file_rd_data),
   .file_addr(file_addr),
   .file_wr_data(file_wr_data),
   .file_wr_en(file_wr_en),
   .accumulator(accumulator),
   .nil_flag_wr_en(nil_flag_wr_en),
   .nil_flag_value(nil_flag_value),
   .skip_active(skip_active),
   .handled(handled)
);
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; \
   $display("wrong value at %0t: %h vs %h", $time, a, b); end end
module tb
   import skip_move_pkg::*;
;
   logic core_clk = 0, rst = 1, instr_valid = 0;
   logic [13:0] instr_word = '0;
   logic [7:0] file_rd_data = '0;
   wire [6:0] file_addr;
   wire [7:0] file_wr_data, accumulator;
   wire file_wr_en, nil_flag_wr_en, nil_flag_value, skip_active, handled;
   int fail_count = 0, n_checks = 0;
   skip_move_exec i_dut (.core_clk, .rst, .instr_valid, .instr_word,
      .file_rd_data, .file_addr, .file_wr_data, .file_wr_en, .accumulator,
      .nil_flag_wr_en, .nil_flag_value, .skip_active, .handled);
   initial forever #50 core_clk = ~core_clk;
   // ------------------------------
   // Slot driver and scenarios
   // ------------------------------
   task automatic ex(input logic [13:0] w, input logic [7:0] rd);
      instr_word = w;
      file_rd_data = rd;
      instr_valid = 1;
      @(posedge core_clk);
      #1;
   endtask
   task automatic t_skip();
      ex(14'h0B05, 8'h01);
      `CHK({accumulator, skip_active, nil_flag_wr_en}, 10'h002)
      ex(14'h30FF, 8'h00);
      `CHK({accumulator, skip_active, handled}, 10'h000)
      ex(14'h0B85, 8'h00);
      `CHK({file_wr_data, file_addr, file_wr_en}, 16'hFF0B)
      ex(14'h0FFF, 8'hFF);
      `CHK({file_wr_data, skip_active, nil_flag_wr_en}, 10'h002)
      ex(14'h0000, 8'h00);
      `CHK({skip_active, handled, file_wr_en}, 3'h0)
      ex(14'h0F00, 8'h41);
      `CHK({accumulator, skip_active, handled}, 10'h109)
      $display("skip test done");
   endtask
   task automatic t_or();
      ex(14'h30F0, 8'h00);
      ex(14'h380F, 8'h00);
      `CHK({accumulator, nil_flag_wr_en, nil_flag_value},
         10'h3FE)
      ex(14'h3000, 8'h00);
      `CHK({accumulator, nil_flag_wr_en}, 9'h000)
      ex(14'h3800, 8'h00);
      `CHK({nil_flag_wr_en, nil_flag_value}, 2'h3)
      ex(14'h0483, 8'h00);
      `CHK({file_wr_data, file_wr_en, nil_flag_value}, 10'h003)
      ex(14'h3001, 8'h00);
      ex(14'h0403, 8'h80);
      `CHK({accumulator, file_wr_en, nil_flag_value}, 10'h204)
      $display("or test done");
   endtask
   task automatic t_store();
      ex(14'h30A5, 8'h00);
      ex(14'h00FF, 8'h00);
      `CHK({file_wr_data, file_addr, file_wr_en}, 16'hA5FF)
      `CHK(nil_flag_wr_en, 1'b0)
      $display("store test done");
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial begin
      repeat (12) @(posedge core_clk);
      #1 rst = 0;
      `CHK({accumulator, file_wr_en, skip_active}, {ACC_RESET, 2'b00})
      t_skip();
      t_or();
      t_store();
      print_verdict();
   end
endmodule
`default_nettype wire
